// *** hw/pdt_pkg.sv ***
// Constants shared by the power-down and conversion trigger register bank.
// Assumes a 32-bit APB with byte addresses; each register index maps to
// byte address index * 4.
package pdt_pkg;

  // Bus and data widths
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = 4;
  localparam int REG_W    = 8;
  localparam int RES_W    = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_UPPER_DAC   = 8'hB3;
  localparam logic [7:0] IDX_CONV_POWER  = 8'hB4;
  localparam logic [7:0] IDX_TRIGGER     = 8'hC0;
  localparam logic [7:0] IDX_RESULT_BASE = 8'hD0;

  // Result slots: analog inputs first, temperature sensor last
  localparam int SLOT_W      = 5;
  localparam int NUM_ANALOG  = 21;
  localparam int NUM_SLOTS   = 22;
  localparam logic [SLOT_W-1:0] TEMP_SLOT = 5'h15;

  // Field positions
  localparam int ADC_EN_BIT = 0;
  localparam int REF_EN_BIT = 1;
  localparam int START_BIT  = 0;
  localparam int LANE0      = 0;

  // Writable masks; reserved bits stay zero
  localparam logic [REG_W-1:0] UPPER_DAC_MASK  = 8'hFF;
  localparam logic [REG_W-1:0] CONV_POWER_MASK = 8'h03;
  localparam logic [REG_W-1:0] TRIGGER_MASK    = 8'h01;

  // Reset values
  localparam logic [REG_W-1:0] REG_RESET   = 8'h00;
  localparam logic [REG_W-1:0] CLAMP_RESET = 8'hFF;
  localparam logic [RES_W-1:0] RES_RESET   = 12'h000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

// *** hw/pdt_apb_slave.sv ***
// APB slave front end: one wait state, registered ready, data and error.
// Assumes the master holds its request until ready is seen high.
`timescale 1ns/10ps
module pdt_apb_slave
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // APB request
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  // Decode from the register bank
  input  wire logic [DATA_W-1:0] rd_data_i,
  input  wire logic              hit_i,
  // APB answer and write strobe
  output logic [DATA_W-1:0]      prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   wr_fire_o
);
  import pdt_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              err;
  } pdt_slv_t;

  pdt_slv_t st;
  pdt_slv_t next_st;

  // Answer one cycle into the access phase, then drop ready again
  always_comb begin
    next_st       = st;
    next_st.ready = 1'b0;
    if (psel_i && penable_i && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.err   = !hit_i;
      next_st.rdata = (hit_i && !pwrite_i) ? rd_data_i : DATA_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Write lands on the edge that completes the transfer; refused on error
  assign wr_fire_o = psel_i && penable_i && st.ready && pwrite_i && !st.err;
  assign prdata_o  = st.rdata;
  assign pready_o  = st.ready;
  assign pslverr_o = st.err;

endmodule

// *** hw/pdt_result_store.sv ***
// Conversion result store: one word per analog input plus temperature.
// Assumes the converter reports each finished conversion as a one-cycle
// pulse with its slot number and result.
`timescale 1ns/10ps
module pdt_result_store
  import pdt_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Conversion completion
  input  wire logic              done_i,
  input  wire logic [SLOT_W-1:0] done_slot_i,
  input  wire logic [RES_W-1:0]  done_data_i,
  // Read port
  input  wire logic [SLOT_W-1:0] rd_slot_i,
  output logic [RES_W-1:0]       rd_data_o
);
  import pdt_pkg::*;

  typedef struct packed {
    logic [SLOTS-1:0][RES_W-1:0] mem;
  } pdt_res_t;

  pdt_res_t st;
  pdt_res_t next_st;

  // Refreshed by hardware on every completion, no software action
  always_comb begin
    next_st = st;
    if (done_i && (int'(done_slot_i) < SLOTS)) begin
      next_st.mem[done_slot_i] = done_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Out-of-range slots read as zero
  assign rd_data_o = (int'(rd_slot_i) < SLOTS) ? st.mem[rd_slot_i] : RES_RESET;

endmodule

// *** hw/pdt_regs.sv ***
// Power-down control and software conversion trigger register bank.
// Assumes an APB master on the same clock and a converter core that
// acknowledges a start and reports each finished conversion.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module pdt_regs
  import pdt_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  input  wire logic [STRB_W-1:0] pstrb_i,
  output logic [DATA_W-1:0]      prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Converter power controls
  output logic [REG_W-1:0]       dac_clamp_o,
  output logic                   adc_enable_o,
  output logic                   ref_enable_o,
  // Conversion handshake
  output logic                   conv_start_o,
  input  wire logic              conv_started_i,
  input  wire logic              conv_done_i,
  input  wire logic [SLOT_W-1:0] conv_slot_i,
  input  wire logic [RES_W-1:0]  conv_data_i
);
  import pdt_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0] upper_dac;   // dac15_power_on .. dac8_power_on
    logic [REG_W-1:0] conv_power;  // reference_power_on, converter_power_on
    logic             soft_start;  // soft_conversion_start
    logic [REG_W-1:0] clamp;
    logic             adc_en;
    logic             ref_en;
  } pdt_state_t;

  pdt_state_t st;
  pdt_state_t next_st;

  logic [DATA_W-1:0] rd_data;
  logic              hit;
  logic              wr_fire;
  logic              lane0;
  logic [REG_W-1:0]  wbyte;
  logic [RES_W-1:0]  res_data;
  logic [SLOT_W-1:0] res_slot;
  logic [7:0]        idx;
  logic              is_result;

  // Register index within a result window; used by decode and read mux
  function automatic logic in_results(input logic [7:0] i);
    return (i >= IDX_RESULT_BASE) &&
           (int'(i) < int'(IDX_RESULT_BASE) + SLOTS);
  endfunction

  // Widen an 8-bit register to the bus; upper bits read as zero
  function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
    return {{(DATA_W-REG_W){1'b0}}, v};
  endfunction

  // Address decode: aligned word inside the map
  assign idx       = paddr_i[9:2];
  assign is_result = in_results(idx);
  assign res_slot  = SLOT_W'(idx - IDX_RESULT_BASE);
  assign lane0     = pstrb_i[LANE0];
  assign wbyte     = pwdata_i[REG_W-1:0];

  always_comb begin
    hit     = 1'b0;
    rd_data = DATA_ZERO;
    if (paddr_i[ADDR_W-1:10] == '0 && paddr_i[1:0] == 2'b00) begin
      if (idx == IDX_UPPER_DAC) begin
        hit     = 1'b1;
        rd_data = widen(st.upper_dac);
      end else if (idx == IDX_CONV_POWER) begin
        hit     = 1'b1;
        rd_data = widen(st.conv_power & CONV_POWER_MASK);
      end else if (idx == IDX_TRIGGER) begin
        hit     = 1'b1;
        rd_data = widen({{(REG_W-1){1'b0}}, st.soft_start});
      end else if (is_result) begin
        hit     = !pwrite_i; // Results are read-only
        rd_data = {{(DATA_W-RES_W){1'b0}}, res_data};
      end
    end
  end

  // Register updates, conversion start bookkeeping and derived controls
  always_comb begin
    next_st = st;
    // Start bit drops once the converter reports the conversion began;
    // a fresh write of one in that cycle wins so no request is lost
    if (conv_started_i) begin
      next_st.soft_start = 1'b0;
    end
    if (wr_fire && lane0) begin
      unique case (idx)
        IDX_UPPER_DAC:
          next_st.upper_dac = wbyte & UPPER_DAC_MASK;
        IDX_CONV_POWER:
          next_st.conv_power = wbyte & CONV_POWER_MASK;
        IDX_TRIGGER: begin
          if (wbyte[START_BIT] & TRIGGER_MASK[START_BIT]) begin
            next_st.soft_start = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // A cleared bit clamps its DAC; bit 7 is channel 15, bit 0 channel 8
    next_st.clamp  = ~next_st.upper_dac;
    next_st.adc_en = next_st.conv_power[ADC_EN_BIT];
    next_st.ref_en = next_st.conv_power[REF_EN_BIT];
  end

  // All controls power up off, DACs clamped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st.upper_dac  <= REG_RESET;
      st.conv_power <= REG_RESET;
      st.soft_start <= 1'b0;
      st.clamp      <= CLAMP_RESET;
      st.adc_en     <= 1'b0;
      st.ref_en     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Bus front end
  pdt_apb_slave u_slave (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .rd_data_i (rd_data),
    .hit_i     (hit),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .wr_fire_o (wr_fire)
  );

  // Result words, refreshed by the converter
  pdt_result_store #(
    .SLOTS (SLOTS)
  ) u_results (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .done_i      (conv_done_i),
    .done_slot_i (conv_slot_i),
    .done_data_i (conv_data_i),
    .rd_slot_i   (res_slot),
    .rd_data_o   (res_data)
  );

  // Outputs come straight from state flops
  assign dac_clamp_o  = st.clamp;
  assign adc_enable_o = st.adc_en;
  assign ref_enable_o = st.ref_en;
  assign conv_start_o = st.soft_start;

endmodule

// *** testbench/pdt_regs_sva.sv ***
// Checker for the power-down and conversion trigger register bank.
// Sees only the bank's ports; bound from the testbench top.
`timescale 1ns/10ps
module pdt_regs_sva
  import pdt_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
)
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  // APB
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [STRB_W-1:0] pstrb_i,
  input wire logic [DATA_W-1:0] prdata_o,
  input wire logic              pready_o,
  // Controls and handshake
  input wire logic [REG_W-1:0]  dac_clamp_o,
  input wire logic              adc_enable_o,
  input wire logic              ref_enable_o,
  input wire logic              conv_start_o,
  input wire logic              conv_started_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Completed write, and completed write to one address
  sequence s_done;
    psel_i && penable_i && pwrite_i && pready_o;
  endsequence
  sequence s_wr(logic [ADDR_W-1:0] a);
    s_done ##0 pstrb_i[0] && paddr_i == a;
  endsequence
  property p_reset;
    $rose(rst_n_i) |-> dac_clamp_o == 8'hFF && !adc_enable_o
      && !ref_enable_o && !conv_start_o;
  endproperty
  property p_ready;
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
  endproperty
  property p_clamp;
    s_wr(12'h2CC) |=> dac_clamp_o == ~$past(pwdata_i[7:0]);
  endproperty
  property p_power;
    s_wr(12'h2D0) |=> {ref_enable_o, adc_enable_o} == $past(pwdata_i[1:0]);
  endproperty
  // Controls only move on a completed write
  property p_hold;
    !(psel_i && penable_i && pwrite_i && pready_o)
      |=> $stable({ref_enable_o, adc_enable_o, dac_clamp_o});
  endproperty
  property p_start;
    s_wr(12'h300) ##0 pwdata_i[0] |=> conv_start_o;
  endproperty
  property p_clear;
    conv_start_o && conv_started_i
      && !(psel_i && penable_i && pwrite_i && paddr_i == 12'h300)
      |=> !conv_start_o;
  endproperty
  property p_resv;
    pready_o && !pwrite_i && paddr_i == 12'h2D0 |-> prdata_o[31:2] == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values");
  a_ready: assert property (p_ready) else $error("ready timing");
  a_clamp: assert property (p_clamp) else $error("clamp map");
  a_power: assert property (p_power) else $error("enable map");
  a_hold: assert property (p_hold) else $error("control moved");
  a_start: assert property (p_start) else $error("start lost");
  a_clear: assert property (p_clear) else $error("start kept");
  a_resv: assert property (p_resv) else $error("reserved set");
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the power-down and trigger register bank.
// Acts as APB master and converter; bus answers go through a queue.
`timescale 1ns/10ps
module tb;
  import pdt_pkg::*;
  logic              clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
  logic [ADDR_W-1:0] paddr_i;
  logic [DATA_W-1:0] pwdata_i, prdata_o;
  logic [STRB_W-1:0] pstrb_i;
  logic              pready_o, pslverr_o, adc_enable_o, ref_enable_o;
  logic              conv_start_o, conv_started_i, conv_done_i;
  logic [REG_W-1:0]  dac_clamp_o;
  logic [SLOT_W-1:0] conv_slot_i;
  logic [RES_W-1:0]  conv_data_i;
  logic [32:0]       q[$];
  logic [4:0]        sl[3] = '{5'h00, 5'h14, 5'h15};
  logic [31:0]       rs = 32'h6767;
  int                n_mismatch = 0;
  int                compares = 0;

  pdt_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .dac_clamp_o(dac_clamp_o),
    .adc_enable_o(adc_enable_o), .ref_enable_o(ref_enable_o),
    .conv_start_o(conv_start_o), .conv_started_i(conv_started_i),
    .conv_done_i(conv_done_i), .conv_slot_i(conv_slot_i),
    .conv_data_i(conv_data_i));

  // 8 ns clock
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic cmp(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One transfer; the bus is left held so a setup can follow at once
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    q.push_back(e);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      give_verdict;
    end
  endtask

  task idle;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic outs(input logic [7:0] c, input logic [1:0] en,
                      input logic s);
    cmp("clamp", {25'h0, c}, {25'h0, dac_clamp_o});
    cmp("enables", {31'h0, en}, {31'h0, ref_enable_o, adc_enable_o});
    cmp("start", {32'h0, s}, {32'h0, conv_start_o});
  endtask

  // Each completed transfer is compared with the oldest note
  always @(posedge clk_i) begin
    if (rst_n_i && psel_i && penable_i && pready_o === 1'h1) begin
      if (q.size() == 0)
        cmp("extra answer", 33'h0, 33'h1);
      else
        cmp("bus answer", q.pop_front(), {pslverr_o, prdata_o});
    end
  end

  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i} = 4'h0;
    {paddr_i, pwdata_i, conv_slot_i, conv_data_i} = '0;
    {conv_started_i, conv_done_i} = 2'h0;
    pstrb_i = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    outs(8'hFF, 2'h0, 1'h0);
    apb(1'h0, 12'h2CC, '0, 33'h0);
    apb(1'h0, 12'h2D0, '0, 33'h0);
    apb(1'h0, 12'h300, '0, 33'h0);
    // Random power patterns; the host keeps reserved bits at zero
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      apb(1'h1, 12'h2CC, rs, 33'h0);
      apb(1'h1, 12'h2D0, {~rs[31:8], 6'h00, ~rs[1:0]}, 33'h0);
      apb(1'h0, 12'h2CC, '0, {25'h0, rs[7:0]});
      apb(1'h0, 12'h2D0, '0, {31'h0, ~rs[1:0]});
      idle;
      outs(~rs[7:0], ~rs[1:0], 1'h0);
    end
    // Refused accesses must leave the controls alone
    apb(1'h0, 12'h004, '0, 33'h1_0000_0000);
    apb(1'h1, 12'h2CE, '0, 33'h1_0000_0000);
    apb(1'h1, 12'hECC, '0, 33'h1_0000_0000);
    apb(1'h1, 12'h340, '0, 33'h1_0000_0000);
    // A write without its low byte lane is accepted but changes nothing
    pstrb_i <= 4'hE;
    apb(1'h1, 12'h2CC, 32'h0, 33'h0);
    pstrb_i <= 4'hF;
    idle;
    outs(~rs[7:0], ~rs[1:0], 1'h0);
    // Start, a zero write cannot abort it, then the converter acks
    apb(1'h1, 12'h300, 32'hFFFF_FF01, 33'h0);
    apb(1'h1, 12'h300, 32'h0, 33'h0);
    apb(1'h0, 12'h300, '0, 33'h1);
    idle;
    outs(~rs[7:0], ~rs[1:0], 1'h1);
    conv_started_i <= 1'h1;
    @(posedge clk_i);
    conv_started_i <= 1'h0;
    @(posedge clk_i);
    outs(~rs[7:0], ~rs[1:0], 1'h0);
    apb(1'h0, 12'h300, '0, 33'h0);
    idle;
    // Results refresh on every completion, temperature slot included
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      conv_done_i <= 1'h1;
      conv_slot_i <= sl[i % 3];
      conv_data_i <= rs[11:0];
      @(posedge clk_i);
      conv_done_i <= 1'h0;
      apb(1'h0, 12'h340 + {5'h0, sl[i % 3], 2'h0}, '0,
          {21'h0, rs[11:0]});
      idle;
    end
    // Reset in mid-run
    rst_n_i <= 1'h0;
    @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    outs(8'hFF, 2'h0, 1'h0);
    apb(1'h0, 12'h2CC, '0, 33'h0);
    idle;
    give_verdict;
  end
endmodule

bind pdt_regs pdt_regs_sva #(.SLOTS(SLOTS)) i_sva (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .dac_clamp_o(dac_clamp_o), .adc_enable_o(adc_enable_o),
  .ref_enable_o(ref_enable_o), .conv_start_o(conv_start_o),
  .conv_started_i(conv_started_i));
